// file: hw/pnv_host_ctrl.sv
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
module pnv_host_ctrl #(
  parameter int ACCESS_NS = pnv_pkg::ADDRESS_ACCESS_TIME_NS,
  parameter int PRECHARGE_NS = pnv_pkg::PRECHARGE_MIN_TIME_NS,
  parameter int SLEEP_EXIT_NS = pnv_pkg::SLEEP_EXIT_DELAY_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Memory pins
  output logic [pnv_pkg::ADDR_W-1:0] mem_addr_o,
  output logic chip_sel_n_o,
  output logic write_strobe_n_o,
  output logic output_drive_n_o,
  output logic upper_byte_sel_n_o,
  output logic lower_byte_sel_n_o,
  output logic sleep_request_n_o,
  // Data bus, three signals of the two-way pin
  input wire logic [pnv_pkg::DATA_W-1:0] data_bus_i,
  output logic [pnv_pkg::DATA_W-1:0] data_bus_o,
  output logic data_bus_oe_o
);
  localparam logic [pnv_pkg::CNT_W-1:0] ACC_CYC = pnv_pkg::CNT_W'(pnv_pkg::min_cycles(ACCESS_NS));
  localparam logic [pnv_pkg::CNT_W-1:0] RD_CYC = pnv_pkg::CNT_W'(pnv_pkg::min_cycles(ACCESS_NS)
    + pnv_pkg::SYNC_CYCLES);
  localparam logic [pnv_pkg::CNT_W-1:0] PC_CYC = pnv_pkg::CNT_W'(pnv_pkg::min_cycles(PRECHARGE_NS));
  localparam logic [pnv_pkg::CNT_W-1:0] ZZ_CYC = pnv_pkg::CNT_W'(pnv_pkg::min_cycles(SLEEP_EXIT_NS));
  localparam logic [pnv_pkg::CNT_W-1:0] CNT_ONE = 16'h0001;

  pnv_pkg::pnv_state_type state_reg, state_next;
  logic [pnv_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] step_reg, step_next;
  logic prot_mode_reg, prot_mode_next;
  logic is_write_reg, is_write_next;
  logic [pnv_pkg::ADDR_W-1:0] addr_cfg_reg, addr_cfg_next;
  logic [pnv_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic [1:0] bytesel_reg, bytesel_next;
  logic [pnv_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic refused_reg, refused_next;
  logic [31:0] rd_out_reg, rd_out_next;
  logic [pnv_pkg::ADDR_W-1:0] pin_addr_reg, pin_addr_next;
  logic ce_n_reg, ce_n_next;
  logic we_n_reg, we_n_next;
  logic oe_n_reg, oe_n_next;
  logic zz_n_reg, zz_n_next;
  logic [pnv_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic [pnv_pkg::DATA_W-1:0] sync1_reg, sync2_reg;
  logic cmd_go;
  logic [2:0] cmd;
  logic cnt_done;
  assign cmd_go = reg_wr_i && (reg_addr_i == pnv_pkg::REG_CMD);
  assign cmd = reg_wdata_i[2:0];
  assign cnt_done = (cnt_reg == CNT_ONE);
  // Data word for a given step of the protection sequence
  function automatic logic [pnv_pkg::DATA_W-1:0] prot_data(input logic [3:0] step,
                                                          input logic [pnv_pkg::PROT_W-1:0] pbyte);
    if (step == 4'(pnv_pkg::PROT_FIRST_WR)) return {{(pnv_pkg::DATA_W-pnv_pkg::PROT_W){1'b0}}, pbyte};
    if (step == 4'(pnv_pkg::PROT_CPL_WR)) return {{(pnv_pkg::DATA_W-pnv_pkg::PROT_W){1'b0}}, ~pbyte};
    return '0;
  endfunction

  function automatic logic prot_is_write(input logic [3:0] step);
    prot_is_write = (step >= 4'(pnv_pkg::PROT_FIRST_WR)) && (step <= 4'(pnv_pkg::PROT_LAST_WR));
  endfunction

  // Pins are asynchronous to us: two flops before use
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= data_bus_i;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    step_next = step_reg;
    prot_mode_next = prot_mode_reg;
    is_write_next = is_write_reg;
    addr_cfg_next = addr_cfg_reg;
    wdata_next = wdata_reg;
    bytesel_next = bytesel_reg;
    rdata_next = rdata_reg;
    refused_next = refused_reg;
    pin_addr_next = pin_addr_reg;
    ce_n_next = ce_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    zz_n_next = zz_n_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rd_out_next = 32'h00000000;
    if (reg_wr_i && reg_addr_i == pnv_pkg::REG_ADDR) addr_cfg_next = reg_wdata_i[pnv_pkg::ADDR_W-1:0];
    if (reg_wr_i && reg_addr_i == pnv_pkg::REG_WDATA) wdata_next = reg_wdata_i[pnv_pkg::DATA_W-1:0];
    if (reg_wr_i && reg_addr_i == pnv_pkg::REG_BYTESEL) bytesel_next = reg_wdata_i[1:0];
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        pnv_pkg::REG_ADDR: rd_out_next = 32'(addr_cfg_reg);
        pnv_pkg::REG_WDATA: rd_out_next = 32'(wdata_reg);
        pnv_pkg::REG_BYTESEL: rd_out_next = 32'(bytesel_reg);
        pnv_pkg::REG_RDATA: rd_out_next = 32'(rdata_reg);
        pnv_pkg::REG_STATUS: rd_out_next = 32'({refused_reg, (state_reg == pnv_pkg::S_SLEEP),
                                                 (state_reg != pnv_pkg::S_IDLE && state_reg != pnv_pkg::S_SLEEP)});
        default: rd_out_next = 32'h00000000;
      endcase
      // Reading status clears the refused flag
      if (reg_addr_i == pnv_pkg::REG_STATUS) refused_next = 1'b0;
    end
    unique case (state_reg)
      pnv_pkg::S_IDLE: begin
        if (cmd_go) begin
          if (cmd == pnv_pkg::CMD_READ || cmd == pnv_pkg::CMD_WRITE) begin
            prot_mode_next = 1'b0;
            is_write_next = (cmd == pnv_pkg::CMD_WRITE);
            pin_addr_next = addr_cfg_reg;
            dout_next = wdata_reg;
            state_next = pnv_pkg::S_SELECT;
          end else if (cmd == pnv_pkg::CMD_PROTECT) begin
            prot_mode_next = 1'b1;
            step_next = 4'h0;
            is_write_next = 1'b0;
            pin_addr_next = pnv_pkg::prot_addr(4'h0);
            state_next = pnv_pkg::S_SELECT;
          end else if (cmd == pnv_pkg::CMD_SLEEP) begin
            zz_n_next = 1'b0;
            state_next = pnv_pkg::S_SLEEP;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      pnv_pkg::S_SELECT: begin
        // Select falls first with write strobe high; a write strobe only follows a cycle later
        ce_n_next = 1'b0;
        oe_n_next = is_write_reg;
        if (!is_write_reg) begin
          cnt_next = RD_CYC;
          state_next = pnv_pkg::S_READ_WAIT;
        end else if (!ce_n_reg) begin
          we_n_next = 1'b0;
          doe_next = 1'b1;
          cnt_next = ACC_CYC;
          state_next = pnv_pkg::S_WRITE_LOW;
        end
      end
      pnv_pkg::S_READ_WAIT: begin
        if (cnt_done) begin
          rdata_next = sync2_reg;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
          cnt_next = PC_CYC;
          state_next = pnv_pkg::S_PRECHARGE;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      pnv_pkg::S_WRITE_LOW: begin
        if (cnt_done) begin
          we_n_next = 1'b1;
          state_next = pnv_pkg::S_WRITE_END;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      pnv_pkg::S_WRITE_END: begin
        // Data held one cycle past the strobe rise, then select rises
        ce_n_next = 1'b1;
        doe_next = 1'b0;
        cnt_next = PC_CYC;
        state_next = pnv_pkg::S_PRECHARGE;
      end
      pnv_pkg::S_PRECHARGE: begin
        if (cnt_done) begin
          if (prot_mode_reg && step_reg != 4'(pnv_pkg::PROT_LAST_STEP)) begin
            step_next = step_reg + 4'h1;
            pin_addr_next = pnv_pkg::prot_addr(step_reg + 4'h1);
            is_write_next = prot_is_write(step_reg + 4'h1);
            dout_next = prot_data(step_reg + 4'h1, wdata_reg[pnv_pkg::PROT_W-1:0]);
            state_next = pnv_pkg::S_SELECT;
          end else begin
            prot_mode_next = 1'b0;
            state_next = pnv_pkg::S_IDLE;
          end
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      pnv_pkg::S_SLEEP: begin
        if (cmd_go) begin
          if (cmd == pnv_pkg::CMD_WAKE) begin
            zz_n_next = 1'b1;
            cnt_next = ZZ_CYC;
            state_next = pnv_pkg::S_WAKE;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      pnv_pkg::S_WAKE: begin
        if (cnt_done) begin
          state_next = pnv_pkg::S_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
    endcase
    // Any command while busy is refused; set wins over the status-read clear
    if (cmd_go && state_reg != pnv_pkg::S_IDLE && state_reg != pnv_pkg::S_SLEEP) refused_next = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= pnv_pkg::S_IDLE;
      cnt_reg <= '0;
      step_reg <= 4'h0;
      prot_mode_reg <= 1'b0;
      is_write_reg <= 1'b0;
      addr_cfg_reg <= '0;
      wdata_reg <= '0;
      bytesel_reg <= pnv_pkg::BYTESEL_RESET;
      rdata_reg <= '0;
      refused_reg <= 1'b0;
      rd_out_reg <= 32'h00000000;
      pin_addr_reg <= '0;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      zz_n_reg <= 1'b1;
      dout_reg <= '0;
      doe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      prot_mode_reg <= prot_mode_next;
      is_write_reg <= is_write_next;
      addr_cfg_reg <= addr_cfg_next;
      wdata_reg <= wdata_next;
      bytesel_reg <= bytesel_next;
      rdata_reg <= rdata_next;
      refused_reg <= refused_next;
      rd_out_reg <= rd_out_next;
      pin_addr_reg <= pin_addr_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      zz_n_reg <= zz_n_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  assign reg_rdata_o = rd_out_reg;
  assign mem_addr_o = pin_addr_reg;
  assign chip_sel_n_o = ce_n_reg;
  assign write_strobe_n_o = we_n_reg;
  assign output_drive_n_o = oe_n_reg;
  // Byte selects held low only while selected, so protection writes reach the low byte
  assign lower_byte_sel_n_o = ce_n_reg | ~(bytesel_reg[0] | prot_mode_reg);
  assign upper_byte_sel_n_o = ce_n_reg | ~(bytesel_reg[1] & ~prot_mode_reg);
  assign sleep_request_n_o = zz_n_reg;
  assign data_bus_o = dout_reg;
  assign data_bus_oe_o = doe_reg;
endmodule

// file: hw/pnv_pkg.sv
package pnv_pkg;
  localparam int CLK_MHZ = 10;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int PROT_W = 8;
  localparam int CNT_W = 16;
  localparam int SYNC_CYCLES = 2;
  localparam int PROT_STEPS = 10;
  localparam int PROT_FIRST_WR = 6;
  localparam int PROT_CPL_WR = 7;
  localparam int PROT_LAST_WR = 8;
  localparam int PROT_LAST_STEP = 9;
  // Default times in ns
  localparam int ADDRESS_ACCESS_TIME_NS = 60;
  localparam int PRECHARGE_MIN_TIME_NS = 100;
  localparam int SLEEP_EXIT_DELAY_NS = 1000;
  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_BYTESEL = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  // Commands
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_PROTECT = 3'h3;
  localparam logic [2:0] CMD_SLEEP = 3'h4;
  localparam logic [2:0] CMD_WAKE = 3'h5;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_ASLEEP = 1;
  localparam int ST_REFUSED = 2;
  localparam logic [1:0] BYTESEL_RESET = 2'h3;

  typedef enum {S_IDLE, S_SELECT, S_READ_WAIT, S_WRITE_LOW, S_WRITE_END, S_PRECHARGE, S_SLEEP, S_WAKE}
    pnv_state_type;

  // Least time rounded up to whole cycles, at least one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic [ADDR_W-1:0] prot_addr(input logic [3:0] step);
    case (step)
      4'h0: prot_addr = 17'h12555;
      4'h1: prot_addr = 17'h1DAAA;
      4'h2: prot_addr = 17'h01333;
      4'h3: prot_addr = 17'h0ECCC;
      4'h4: prot_addr = 17'h000FF;
      4'h5: prot_addr = 17'h1FF00;
      4'h6: prot_addr = 17'h1DAAA;
      4'h7: prot_addr = 17'h0ECCC;
      4'h8: prot_addr = 17'h0FF00;
      default: prot_addr = 17'h00000;
    endcase
  endfunction
endpackage

// file: testbench/pnv_fram_model.sv
`timescale 1ns/100ps
module pnv_fram_model #(
  parameter int ACC_CYC = 1
) (
  // Sampling clock
  input wire logic clk_i,
  // Strobes and address
  input wire logic chip_sel_n_i, write_strobe_n_i, output_drive_n_i, upper_byte_sel_n_i, lower_byte_sel_n_i,
  input wire logic sleep_request_n_i,
  input wire logic [16:0] addr_i,
  // Host side of the data pins
  input wire logic [15:0] host_data_i,
  input wire logic host_oe_i,
  // Level on the data pins
  output logic [15:0] data_bus_o
);
  localparam logic [16:0] SEQ [10] = '{17'h12555, 17'h1DAAA, 17'h01333, 17'h0ECCC, 17'h000FF,
    17'h1FF00, 17'h1DAAA, 17'h0ECCC, 17'h0FF00, 17'h00000};
  logic [15:0] mem [131072];
  logic [15:0] last = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [7:0] prot = 8'h00;
  logic [7:0] pend = 8'h00;
  logic cs_q = 1'b1;
  logic we_q = 1'b1;
  logic wr_seen = 1'b0;
  logic [14:0] row_q = 15'h0000;
  logic ok;
  logic drive;
  int step = 0;
  int cnt = 0;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  assign drive = sleep_request_n_i && !chip_sel_n_i && !output_drive_n_i && write_strobe_n_i && cnt >= ACC_CYC;
  // Idle lanes show the inverse of the last level, so stale data never reads as valid
  assign data_bus_o = host_oe_i ? host_data_i : {(drive && !upper_byte_sel_n_i) ? mem[addr_i][15:8] : ~last[15:8],
    (drive && !lower_byte_sel_n_i) ? mem[addr_i][7:0] : ~last[7:0]};
  // Sampled mid-cycle, away from the edge on which the host launches
  always @(negedge clk_i) begin
    last = data_bus_o;
    if (sleep_request_n_i) begin
      // A new row under select restarts the access, so data waits for the full access time
      cnt = (chip_sel_n_i || addr_i[16:2] != row_q) ? 0 : cnt + 1;
      if (!cs_q && !we_q && (write_strobe_n_i || chip_sel_n_i)) begin
        wd = data_bus_o;
        wr_seen = 1'b1;
        if (!(step inside {6, 7, 8} && addr_i == SEQ[step]) && !prot[addr_i[16:14]]) begin
          if (!upper_byte_sel_n_i) mem[addr_i][15:8] = wd[15:8];
          if (!lower_byte_sel_n_i) mem[addr_i][7:0] = wd[7:0];
        end
      end
      if (!cs_q && chip_sel_n_i) begin
        ok = addr_i == SEQ[step] && wr_seen == (step inside {6, 7, 8}) && !(step == 7 && wd[7:0] != ~pend);
        if (step == 6) pend = wd[7:0];
        if (step == 7 && ok) prot = pend;
        step = (ok && step != 9) ? step + 1 : 0;
        wr_seen = 1'b0;
      end
      cs_q = chip_sel_n_i;
      we_q = write_strobe_n_i;
      row_q = addr_i[16:2];
    end
  end
endmodule

// file: testbench/pnv_host_ctrl_asserts.sv
`timescale 1ns/100ps
module pnv_host_ctrl_asserts #(
  parameter int SLEEP_EXIT_NS = pnv_pkg::SLEEP_EXIT_DELAY_NS
) (
  // Clock and reset
  input wire logic clk_i, rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i, reg_rdata_o,
  input wire logic reg_wr_i, reg_rd_i,
  // Memory pins
  input wire logic [16:0] mem_addr_o,
  input wire logic chip_sel_n_o, write_strobe_n_o, output_drive_n_o, upper_byte_sel_n_o, lower_byte_sel_n_o,
  input wire logic sleep_request_n_o, data_bus_oe_o,
  input wire logic [15:0] data_bus_i, data_bus_o
);
  localparam int WAKE_CYC = (SLEEP_EXIT_NS * pnv_pkg::CLK_MHZ + 999) / 1000;
  int wake_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts the exit delay, during which no access may start
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) wake_cnt <= 0;
    else if ($rose(sleep_request_n_o)) wake_cnt <= WAKE_CYC;
    else if (wake_cnt != 0) wake_cnt <= wake_cnt - 1;
  end
  AST_READ_START: assert property ($fell(chip_sel_n_o) |-> write_strobe_n_o)
    else $error("select fell with write strobe low");
  AST_ADDR_STABLE: assert property (!chip_sel_n_o && $past(chip_sel_n_o) == 1'b0 |-> $stable(mem_addr_o))
    else $error("address moved while selected");
  AST_BYTE_SEL: assert property (!upper_byte_sel_n_o || !lower_byte_sel_n_o |-> !chip_sel_n_o)
    else $error("byte select low outside an access");
  AST_NO_FIGHT: assert property (data_bus_oe_o |-> output_drive_n_o)
    else $error("host drives while device output enabled");
  AST_WRITE_DRIVE: assert property (!write_strobe_n_o |-> data_bus_oe_o && output_drive_n_o && !chip_sel_n_o)
    else $error("write strobe low without host data");
  AST_WE_AFTER_CS: assert property ($fell(write_strobe_n_o) |-> $past(chip_sel_n_o) == 1'b0)
    else $error("write strobe fell before select");
  AST_DATA_HOLD: assert property ($rose(write_strobe_n_o) |-> $stable(data_bus_o) && data_bus_oe_o && !chip_sel_n_o)
    else $error("write data not held to the ending edge");
  AST_WE_PULSE: assert property ($fell(write_strobe_n_o) |=> $rose(write_strobe_n_o))
    else $error("write pulse length wrong");
  AST_PRECHARGE: assert property ($rose(chip_sel_n_o) |=> chip_sel_n_o)
    else $error("precharge too short");
  AST_SLEEP_QUIET: assert property (!sleep_request_n_o |-> chip_sel_n_o && write_strobe_n_o)
    else $error("access during sleep");
  AST_SLEEP_EXIT: assert property (wake_cnt != 0 |-> chip_sel_n_o)
    else $error("access inside sleep exit delay");
  AST_SELECT_TOGGLE: assert property ($fell(chip_sel_n_o) |-> ##[1:12] $rose(chip_sel_n_o))
    else $error("select held low too long");
  cover property ($fell(write_strobe_n_o));
  cover property ($fell(sleep_request_n_o));
  cover property ($rose(chip_sel_n_o) ##1 chip_sel_n_o);
endmodule
bind pnv_host_ctrl pnv_host_ctrl_asserts #(.SLEEP_EXIT_NS(SLEEP_EXIT_NS)) u_pnv_host_ctrl_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .mem_addr_o(mem_addr_o), .chip_sel_n_o(chip_sel_n_o),
  .write_strobe_n_o(write_strobe_n_o), .output_drive_n_o(output_drive_n_o), .upper_byte_sel_n_o(upper_byte_sel_n_o),
  .lower_byte_sel_n_o(lower_byte_sel_n_o), .sleep_request_n_o(sleep_request_n_o), .data_bus_oe_o(data_bus_oe_o),
  .data_bus_i(data_bus_i), .data_bus_o(data_bus_o));

// file: testbench/test_pnv_host_ctrl.sv
`timescale 1ns/100ps
module test_pnv_host_ctrl;
  typedef struct packed {logic [16:0] a; logic [15:0] d; logic [1:0] b; logic [15:0] e;} pnv_row_type;
  localparam pnv_row_type ROWS [5] = '{'{17'h1FFFF, 16'hA55A, 2'h3, 16'hA55A}, '{17'h00003, 16'h1234, 2'h1, 16'h0034},
    '{17'h00003, 16'hABCD, 2'h2, 16'hAB34}, '{17'h04000, 16'hFFFF, 2'h3, 16'hFFFF}, '{17'h04000, 16'h0000, 2'h2, 16'h00FF}};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, v;
  logic [16:0] mem_addr_o;
  logic chip_sel_n_o, write_strobe_n_o, output_drive_n_o, upper_byte_sel_n_o, lower_byte_sel_n_o, sleep_request_n_o;
  logic [15:0] data_bus_i, data_bus_o;
  logic data_bus_oe_o;
  int n_mismatch = 0;
  int tests_run = 0;
  always #50 clk_i = ~clk_i;
  pnv_host_ctrl u_pnv_host_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o),
    .chip_sel_n_o(chip_sel_n_o), .write_strobe_n_o(write_strobe_n_o), .output_drive_n_o(output_drive_n_o),
    .upper_byte_sel_n_o(upper_byte_sel_n_o), .lower_byte_sel_n_o(lower_byte_sel_n_o),
    .sleep_request_n_o(sleep_request_n_o), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o));
  pnv_fram_model u_pnv_fram_model (.clk_i(clk_i), .chip_sel_n_i(chip_sel_n_o), .write_strobe_n_i(write_strobe_n_o),
    .output_drive_n_i(output_drive_n_o), .upper_byte_sel_n_i(upper_byte_sel_n_o), .lower_byte_sel_n_i(lower_byte_sel_n_o),
    .sleep_request_n_i(sleep_request_n_o), .addr_i(mem_addr_o), .host_data_i(data_bus_o), .host_oe_i(data_bus_oe_o),
    .data_bus_o(data_bus_i));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask
  // Bounded poll; a hang ends the run as a failure
  task automatic wait_idle;
    logic [31:0] s;
    for (int i = 0; i < 50; i++) begin
      rd(pnv_pkg::REG_STATUS, s);
      if (s[pnv_pkg::ST_BUSY] === 1'b0) return;
    end
    n_mismatch++;
    $display("ERROR at %0t: controller stays busy", $time);
    summarize();
  endtask
  task automatic op(input logic [2:0] c);
    wr(pnv_pkg::REG_CMD, {29'h00000000, c});
    wait_idle();
  endtask
  task automatic mem_write(input logic [16:0] a, input logic [15:0] d, input logic [1:0] b);
    wr(pnv_pkg::REG_ADDR, {15'h0000, a});
    wr(pnv_pkg::REG_WDATA, {16'h0000, d});
    wr(pnv_pkg::REG_BYTESEL, {30'h00000000, b});
    op(pnv_pkg::CMD_WRITE);
  endtask
  task automatic mem_read(input logic [16:0] a, input logic [15:0] e);
    wr(pnv_pkg::REG_ADDR, {15'h0000, a});
    wr(pnv_pkg::REG_BYTESEL, 32'h00000003);
    op(pnv_pkg::CMD_READ);
    rd(pnv_pkg::REG_RDATA, v);
    check(v, {16'h0000, e});
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    check({27'h0000000, chip_sel_n_o, write_strobe_n_o, output_drive_n_o, sleep_request_n_o, data_bus_oe_o}, 32'h0000001E);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(pnv_pkg::REG_BYTESEL, v);
    check(v, 32'h00000003);
    rd(8'h20, v);
    check(v, 32'h00000000);
    rd(pnv_pkg::REG_CMD, v);
    check(v, 32'h00000000);
    foreach (ROWS[i]) begin
      mem_write(ROWS[i].a, ROWS[i].d, ROWS[i].b);
      mem_read(ROWS[i].a, ROWS[i].e);
    end
    mem_write(17'h0C000, 16'h1111, 2'h3);
    wr(pnv_pkg::REG_WDATA, 32'h00000018);
    op(pnv_pkg::CMD_PROTECT);
    mem_write(17'h0C000, 16'h2222, 2'h3);
    mem_read(17'h0C000, 16'h1111);
    mem_write(17'h13FFF, 16'h5555, 2'h3);
    mem_read(17'h13FFF, 16'h0000);
    mem_write(17'h0BFFF, 16'h3333, 2'h3);
    mem_read(17'h0BFFF, 16'h3333);
    mem_read(17'h1DAAA, 16'h0000);
    wr(pnv_pkg::REG_WDATA, 32'h00000000);
    op(pnv_pkg::CMD_PROTECT);
    mem_write(17'h0C000, 16'h4444, 2'h3);
    mem_read(17'h0C000, 16'h4444);
    // A second order while one runs must be turned away
    wr(pnv_pkg::REG_CMD, 32'h00000001);
    wr(pnv_pkg::REG_CMD, 32'h00000001);
    rd(pnv_pkg::REG_STATUS, v);
    check(v & 32'h00000005, 32'h00000005);
    wait_idle();
    wr(pnv_pkg::REG_CMD, 32'h00000007);
    rd(pnv_pkg::REG_STATUS, v);
    check(v, 32'h00000004);
    op(pnv_pkg::CMD_SLEEP);
    check({31'h00000000, sleep_request_n_o}, 32'h00000000);
    wr(pnv_pkg::REG_CMD, 32'h00000001);
    rd(pnv_pkg::REG_STATUS, v);
    check(v, 32'h00000006);
    op(pnv_pkg::CMD_WAKE);
    check({31'h00000000, sleep_request_n_o}, 32'h00000001);
    mem_read(17'h1FFFF, 16'hA55A);
    summarize();
  end
endmodule
